// ===== hdl/tlc_top.sv
// trigger logic blocks, software pulses, event counters and pulse timers
`timescale 1ns/1ps
`default_nettype none
module tlc_top (
	input  wire logic                        mclk,     // system clock
	input  wire logic                        rst_n,    // async reset, low
	input  wire logic [tlc_pkg::NEXT-1:0]    ext_in,   // external triggers
	input  wire logic                        cfg_we,   // feature write strobe
	input  wire logic [tlc_pkg::FEAT_W-1:0]  cfg_feat, // feature code
	input  wire logic [tlc_pkg::SEL_W-1:0]   cfg_sel,  // instance selector
	input  wire logic [tlc_pkg::SUB_W-1:0]   cfg_sub,  // block input selector
	input  wire logic [tlc_pkg::DATA_W-1:0]  cfg_data, // write data
	output logic      [tlc_pkg::DATA_W-1:0]  rd_data,  // selected feature
	output logic      [tlc_pkg::NLB-1:0]     lb_out,   // logic block outputs
	output logic      [tlc_pkg::NSW-1:0]     sw_out,   // software pulses
	output logic      [tlc_pkg::NTMR-1:0]    tmr_out   // timer pulses
);
	import tlc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	logic [DATA_W-1:0]  rd_data_reg;             // read-back register
	logic [DATA_W-1:0]  rd_data_next;            // read-back mux
	logic [NSRC-1:0]    src_vec;                 // all selectable sources
	logic [NSRC-1:0]    src_prev_reg;            // sources, last cycle
	logic               lb_out_reg  [NLB];       // block outputs
	logic               lb_val      [NLB];       // block function result
	logic               lb_func_reg [NLB];       // and / or
	logic [NUM_W-1:0]   lb_innum_reg[NLB];       // active input count
	logic [SRC_W-1:0]   lb_insrc_reg[NLB][NIN];  // input routing
	logic               lb_inv_reg  [NLB][NIN];  // input inverters
	logic               sw_out_reg  [NSW];       // software pulses
	logic [SRC_W-1:0]   cnt_evsrc_reg [NCNT];    // count source
	logic [SRC_W-1:0]   cnt_rstsrc_reg[NCNT];    // reset source
	logic [1:0]         cnt_rstact_reg[NCNT];    // reset activation
	logic [DATA_W-1:0]  cnt_reg       [NCNT];    // counts
	logic               cnt_ev        [NCNT];    // event seen
	logic               cnt_hwrst     [NCNT];    // reset source active
	logic               cnt_swrst     [NCNT];    // software reset
	logic               cnt_load      [NCNT];    // value write
	logic [DATA_W-1:0]  tmr_delay_reg [NTMR];    // delay, us
	logic [DATA_W-1:0]  tmr_dur_reg   [NTMR];    // duration, us
	logic [SRC_W-1:0]   tmr_trgsrc_reg[NTMR];    // trigger source
	logic [1:0]         tmr_trgact_reg[NTMR];    // trigger activation
	logic [DATA_W-1:0]  tmr_val_reg   [NTMR];    // remaining us of phase
	tlc_tmr_state_t     tmr_st_reg    [NTMR];    // phase
	logic               tmr_on_reg    [NTMR];    // pulse output
	logic               tmr_trg       [NTMR];    // trigger seen
	logic               tmr_load      [NTMR];    // value write
	logic [TICK_W-1:0]  tick_cnt_reg;            // tick divider
	logic               tick_reg;                // one-cycle us enable

	////////////////////////////////////////////////////////////////////////
	// source vector; only flopped signals feed back, so no comb loops
	assign src_vec = {5'h00, tmr_on_reg[1], tmr_on_reg[0], lb_out_reg[1],
		lb_out_reg[0], sw_out_reg[1], sw_out_reg[0], ext_in, 1'b0};
	assign rd_data = rd_data_reg;

	// edge history for the rise and fall activation modes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_prev_reg <= '0;
			rd_data_reg  <= '0;
		end else begin
			src_prev_reg <= src_vec;
			rd_data_reg  <= rd_data_next;
		end
	end

	// microsecond tick; phase is free running, so timing is +0/-1 us
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else begin
			tick_reg     <= (tick_cnt_reg == TICK_LAST);   // RULE_16
			tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0
				: tick_cnt_reg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// logic blocks
	genvar gi, gj;
	generate
		for (gi = 0; gi < NLB; gi++) begin : g_lb
			logic sel_hit;      // this block selected
			logic [NIN-1:0] in_v;   // routed, inverted inputs
			logic [NIN-1:0] in_act; // input counted as active
			assign sel_hit = cfg_we && (cfg_sel == SEL_W'(gi));
			for (gj = 0; gj < NIN; gj++) begin : g_in
				assign in_v[gj] = src_vec[lb_insrc_reg[gi][gj]]   // RULE_03
					^ lb_inv_reg[gi][gj];                     // RULE_04
				assign in_act[gj] = (NUM_W'(gj) < lb_innum_reg[gi]); // RULE_02
				// routing and inverter writes go to the selected input
				always_ff @(posedge mclk or negedge rst_n) begin
					if (!rst_n) begin
						lb_insrc_reg[gi][gj] <= SRC_RST;
						lb_inv_reg[gi][gj]   <= 1'b0;
					end else if (sel_hit && cfg_sub == SUB_W'(gj)) begin
						if (cfg_feat == F_LB_INSRC)
							lb_insrc_reg[gi][gj] <= cfg_data[SRC_W-1:0];
						if (cfg_feat == F_LB_INV)
							lb_inv_reg[gi][gj] <= cfg_data[0];
					end
				end
			end
			// no active inputs gives a quiet output
			assign lb_val[gi] = (in_act == '0) ? 1'b0
				: (lb_func_reg[gi] == FN_AND) ? &(in_v | ~in_act)  // RULE_01
				: |(in_v & in_act);                                 // RULE_01
			assign lb_out[gi] = lb_out_reg[gi];
			// function, input count and registered output
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					lb_func_reg[gi]  <= FN_AND;
					lb_innum_reg[gi] <= INNUM_RST;
					lb_out_reg[gi]   <= 1'b0;
				end else begin
					lb_out_reg[gi] <= lb_val[gi];
					if (sel_hit && cfg_feat == F_LB_FUNC)
						lb_func_reg[gi] <= cfg_data[0];
					if (sel_hit && cfg_feat == F_LB_INNUM)
						lb_innum_reg[gi] <= cfg_data[NUM_W-1:0];
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// software pulse channels: one cycle high per command
		for (gi = 0; gi < NSW; gi++) begin : g_sw
			assign sw_out[gi] = sw_out_reg[gi];
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					sw_out_reg[gi] <= 1'b0;
				else
					sw_out_reg[gi] <= cfg_we && cfg_feat == F_SW_PULSE
						&& cfg_sel == SEL_W'(gi);                // RULE_05
			end
		end

		////////////////////////////////////////////////////////////////////
		// counters: load beats reset beats count; an event in the reset
		// cycle is kept so the count starts at one
		for (gi = 0; gi < NCNT; gi++) begin : g_cnt
			logic sel_hit;  // this counter selected
			assign sel_hit = cfg_we && (cfg_sel == SEL_W'(gi));
			assign cnt_ev[gi] = act_hit(ACT_RISE,
				src_vec[cnt_evsrc_reg[gi]], src_prev_reg[cnt_evsrc_reg[gi]]);
			assign cnt_hwrst[gi] = (cnt_rstsrc_reg[gi] != SRC_ZERO)
				&& act_hit(cnt_rstact_reg[gi], src_vec[cnt_rstsrc_reg[gi]],
				src_prev_reg[cnt_rstsrc_reg[gi]]);                   // RULE_08
			assign cnt_swrst[gi] = sel_hit && cfg_feat == F_CNT_RESET;
			assign cnt_load[gi]  = sel_hit && cfg_feat == F_CNT_VALUE;
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_evsrc_reg[gi]  <= SRC_RST;
					cnt_rstsrc_reg[gi] <= SRC_RST;
					cnt_rstact_reg[gi] <= ACT_RISE;
					cnt_reg[gi]        <= '0;
				end else begin
					if (sel_hit && cfg_feat == F_CNT_EVSRC)
						cnt_evsrc_reg[gi] <= cfg_data[SRC_W-1:0];
					if (sel_hit && cfg_feat == F_CNT_RSTSRC)
						cnt_rstsrc_reg[gi] <= cfg_data[SRC_W-1:0];
					if (sel_hit && cfg_feat == F_CNT_RSTACT)
						cnt_rstact_reg[gi] <= cfg_data[1:0];
					if (cnt_load[gi])
						cnt_reg[gi] <= cfg_data;                     // RULE_10
					else if (cnt_hwrst[gi] || cnt_swrst[gi])
						cnt_reg[gi] <= DATA_W'(cnt_ev[gi]);    // RULE_07 RULE_09
					else if (cnt_ev[gi])
						cnt_reg[gi] <= cnt_reg[gi] + 32'h1;          // RULE_06
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// timers: idle -> delay -> pulse -> idle, counted in us ticks
		for (gi = 0; gi < NTMR; gi++) begin : g_tmr
			logic sel_hit;  // this timer selected
			assign sel_hit = cfg_we && (cfg_sel == SEL_W'(gi));
			assign tmr_trg[gi] = (tmr_trgsrc_reg[gi] != SRC_ZERO)
				&& act_hit(tmr_trgact_reg[gi], src_vec[tmr_trgsrc_reg[gi]],
				src_prev_reg[tmr_trgsrc_reg[gi]]);         // RULE_13 RULE_14
			assign tmr_load[gi] = sel_hit && cfg_feat == F_TMR_VALUE;
			assign tmr_out[gi]  = tmr_on_reg[gi];
			// configuration writes
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					tmr_delay_reg[gi]  <= '0;
					tmr_dur_reg[gi]    <= '0;
					tmr_trgsrc_reg[gi] <= SRC_RST;
					tmr_trgact_reg[gi] <= ACT_RISE;
				end else if (sel_hit) begin
					if (cfg_feat == F_TMR_DELAY)
						tmr_delay_reg[gi] <= cfg_data;
					if (cfg_feat == F_TMR_DUR)
						tmr_dur_reg[gi] <= cfg_data;
					if (cfg_feat == F_TMR_TRGSRC)
						tmr_trgsrc_reg[gi] <= cfg_data[SRC_W-1:0];
					if (cfg_feat == F_TMR_TRGACT)
						tmr_trgact_reg[gi] <= cfg_data[1:0];
				end
			end
			// phase machine; a value write overrides the remaining time
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					tmr_st_reg[gi]  <= TS_IDLE;
					tmr_val_reg[gi] <= '0;
					tmr_on_reg[gi]  <= 1'b0;
				end else begin
					unique case (tmr_st_reg[gi])
						TS_IDLE: begin
							// triggers only count here
							if (tmr_trg[gi] && tmr_delay_reg[gi] != '0) begin
								tmr_st_reg[gi]  <= TS_DELAY;          // RULE_11
								tmr_val_reg[gi] <= tmr_delay_reg[gi];
							end else if (tmr_trg[gi] && tmr_dur_reg[gi] != '0) begin
								tmr_st_reg[gi]  <= TS_PULSE;
								tmr_val_reg[gi] <= tmr_dur_reg[gi];
								tmr_on_reg[gi]  <= 1'b1;
							end
						end
						TS_DELAY: begin
							// triggers ignored until idle
							if (tick_reg && tmr_val_reg[gi] <= 32'h1) begin // RULE_17
								tmr_st_reg[gi]  <= (tmr_dur_reg[gi] != '0)
									? TS_PULSE : TS_IDLE;
								tmr_val_reg[gi] <= tmr_dur_reg[gi];
								tmr_on_reg[gi]  <= (tmr_dur_reg[gi] != '0);
							end else if (tick_reg)
								tmr_val_reg[gi] <= tmr_val_reg[gi] - 32'h1;
						end
						TS_PULSE: begin
							if (tick_reg && tmr_val_reg[gi] <= 32'h1) begin // RULE_12
								tmr_st_reg[gi]  <= TS_IDLE;
								tmr_val_reg[gi] <= '0;
								tmr_on_reg[gi]  <= 1'b0;
							end else if (tick_reg)
								tmr_val_reg[gi] <= tmr_val_reg[gi] - 32'h1;
						end
					endcase
					if (tmr_load[gi])
						tmr_val_reg[gi] <= cfg_data;                  // RULE_15
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read-back of the addressed feature, one cycle late
	always_comb begin
		unique case (cfg_feat)
			F_LB_FUNC:    rd_data_next = DATA_W'(lb_func_reg[cfg_sel]);
			F_LB_INNUM:   rd_data_next = DATA_W'(lb_innum_reg[cfg_sel]);
			F_LB_INSRC:   rd_data_next = DATA_W'(lb_insrc_reg[cfg_sel][cfg_sub]);
			F_LB_INV:     rd_data_next = DATA_W'(lb_inv_reg[cfg_sel][cfg_sub]);
			F_CNT_EVSRC:  rd_data_next = DATA_W'(cnt_evsrc_reg[cfg_sel]);
			F_CNT_RSTSRC: rd_data_next = DATA_W'(cnt_rstsrc_reg[cfg_sel]);
			F_CNT_RSTACT: rd_data_next = DATA_W'(cnt_rstact_reg[cfg_sel]);
			F_CNT_VALUE:  rd_data_next = cnt_reg[cfg_sel];           // RULE_10
			F_TMR_DELAY:  rd_data_next = tmr_delay_reg[cfg_sel];
			F_TMR_DUR:    rd_data_next = tmr_dur_reg[cfg_sel];
			F_TMR_TRGSRC: rd_data_next = DATA_W'(tmr_trgsrc_reg[cfg_sel]);
			F_TMR_TRGACT: rd_data_next = DATA_W'(tmr_trgact_reg[cfg_sel]);
			F_TMR_VALUE:  rd_data_next = tmr_val_reg[cfg_sel];       // RULE_15
			default:      rd_data_next = '0;  // commands read as zero
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// checks on instance 0
	// a one-input block passes its routed input, after its inverter, whatever the function
	AST_LB_ROUTE: assert property ( // RULE_01 RULE_03 RULE_04
		@(posedge mclk) disable iff (!rst_n)
		(lb_innum_reg[0] == 3'h1 && lb_insrc_reg[0][0] == SRC_EXT0)
		|=> lb_out_reg[0]
		== ($past(ext_in[0]) ^ $past(lb_inv_reg[0][0])))
		else $error("logic block route or invert wrong");
	// no active inputs: quiet under either function
	AST_LB_COUNT: assert property ( // RULE_02
		@(posedge mclk) disable iff (!rst_n)
		lb_innum_reg[0] == 3'h0 |=> !lb_out_reg[0])
		else $error("inactive inputs reached logic block");
	AST_SW_PULSE: assert property ( // RULE_05
		@(posedge mclk) disable iff (!rst_n)
		(cfg_we && cfg_feat == F_SW_PULSE && cfg_sel == 1'b0)
		##1 !(cfg_we && cfg_feat == F_SW_PULSE && cfg_sel == 1'b0)
		|-> sw_out_reg[0] ##1 !sw_out_reg[0])
		else $error("software pulse not one cycle");
	AST_CNT_INC: assert property ( // RULE_06
		@(posedge mclk) disable iff (!rst_n)
		(cnt_ev[0] && !cnt_load[0] && !cnt_hwrst[0] && !cnt_swrst[0])
		|=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1)
		else $error("counter missed an event");
	AST_CNT_CLR: assert property ( // RULE_07 RULE_08 RULE_09
		@(posedge mclk) disable iff (!rst_n)
		((cnt_hwrst[0] || cnt_swrst[0]) && !cnt_load[0])
		|=> cnt_reg[0] == 32'($past(cnt_ev[0])))
		else $error("counter not cleared");
	AST_CNT_LOAD: assert property ( // RULE_10
		@(posedge mclk) disable iff (!rst_n)
		cnt_load[0] |=> cnt_reg[0] == $past(cfg_data))
		else $error("counter load lost");
	AST_TMR_START: assert property ( // RULE_11 RULE_13 RULE_14
		@(posedge mclk) disable iff (!rst_n)
		(tmr_st_reg[0] == TS_IDLE && tmr_trg[0] && !tmr_load[0]
		&& tmr_delay_reg[0] != '0) |=> tmr_st_reg[0] == TS_DELAY
		&& tmr_val_reg[0] == $past(tmr_delay_reg[0]))
		else $error("timer did not start its delay");
	AST_TMR_BUSY: assert property ( // RULE_17
		@(posedge mclk) disable iff (!rst_n)
		(tmr_st_reg[0] != TS_IDLE && tmr_trg[0] && !tick_reg && !tmr_load[0])
		|=> $stable(tmr_val_reg[0]) && $stable(tmr_st_reg[0]))
		else $error("busy timer reacted to trigger");
	AST_TMR_OUT: assert property ( // RULE_12
		@(posedge mclk) disable iff (!rst_n)
		tmr_on_reg[0] == (tmr_st_reg[0] == TS_PULSE))
		else $error("timer output disagrees with phase");
	AST_TICK: assert property ( // RULE_16
		@(posedge mclk) disable iff (!rst_n)
		tick_reg |=> !tick_reg ##249 tick_reg)
		else $error("tick period not 250 cycles");
	AST_TMR_READ: assert property ( // RULE_15
		@(posedge mclk) disable iff (!rst_n)
		(cfg_feat == F_TMR_VALUE && cfg_sel == 1'b0)
		|=> rd_data_reg == $past(tmr_val_reg[0]))
		else $error("timer value read wrong");
endmodule // tlc_top
`default_nettype wire

// ===== hdl/tlc_pkg.sv
// constants, codes and helpers shared by the trigger logic/counter/timer block
// Contract
// RULE_01 - logic block output from selectable function
// RULE_02 - inputs beyond programmed count stay inactive
// RULE_03 - each block input routed from chosen source
// RULE_04 - per-input inverter before the function
// RULE_05 - software pulse command emits one pulse
// RULE_06 - counter increments on selected event
// RULE_07 - counter cleared by selected reset source
// RULE_08 - reset source judged by activation mode
// RULE_09 - software counter reset clears, keeps counting
// RULE_10 - counter value readable and loadable
// RULE_11 - timer waits programmed microsecond delay
// RULE_12 - timer pulse lasts programmed microsecond duration
// RULE_13 - timer trigger from selected source
// RULE_14 - timer trigger judged by activation mode
// RULE_15 - timer value readable and writable
// RULE_16 - one microsecond tick from system clock
// RULE_17 - triggers ignored while timer is busy
`default_nettype none
package tlc_pkg;
	// instance counts
	localparam int NLB  = 2;          // logic blocks
	localparam int NIN  = 4;          // inputs per logic block
	localparam int NSW  = 2;          // software signal channels
	localparam int NCNT = 2;          // counters
	localparam int NTMR = 2;          // timers
	localparam int NEXT = 4;          // external input lines
	// widths
	localparam int SEL_W  = 1;        // instance selector
	localparam int SUB_W  = 2;        // logic block input selector
	localparam int FEAT_W = 4;        // feature code
	localparam int SRC_W  = 4;        // source selector code
	localparam int NUM_W  = 3;        // active input count
	localparam int DATA_W = 32;       // configuration data
	localparam int NSRC   = 16;       // entries of the source vector
	// feature codes on the configuration port
	localparam logic [3:0] F_LB_FUNC    = 4'h0;
	localparam logic [3:0] F_LB_INNUM   = 4'h1;
	localparam logic [3:0] F_LB_INSRC   = 4'h2;
	localparam logic [3:0] F_LB_INV     = 4'h3;
	localparam logic [3:0] F_SW_PULSE   = 4'h4;
	localparam logic [3:0] F_CNT_EVSRC  = 4'h5;
	localparam logic [3:0] F_CNT_RSTSRC = 4'h6;
	localparam logic [3:0] F_CNT_RSTACT = 4'h7;
	localparam logic [3:0] F_CNT_RESET  = 4'h8;
	localparam logic [3:0] F_CNT_VALUE  = 4'h9;
	localparam logic [3:0] F_TMR_DELAY  = 4'ha;
	localparam logic [3:0] F_TMR_DUR    = 4'hb;
	localparam logic [3:0] F_TMR_TRGSRC = 4'hc;
	localparam logic [3:0] F_TMR_TRGACT = 4'hd;
	localparam logic [3:0] F_TMR_VALUE  = 4'he;
	// combinational functions
	localparam logic FN_AND = 1'b0;
	localparam logic FN_OR  = 1'b1;
	// activation modes
	localparam logic [1:0] ACT_RISE = 2'h0;
	localparam logic [1:0] ACT_FALL = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_LOW  = 2'h3;
	// source codes: bit positions in the source vector
	localparam logic [3:0] SRC_ZERO = 4'h0;
	localparam logic [3:0] SRC_EXT0 = 4'h1;
	localparam logic [3:0] SRC_SW0  = 4'h5;
	localparam logic [3:0] SRC_LB0  = 4'h7;
	localparam logic [3:0] SRC_TMR0 = 4'h9;
	// reset values
	localparam logic [2:0] INNUM_RST = 3'h1;
	localparam logic [3:0] SRC_RST   = 4'h0;
	// microsecond tick
	localparam int CLK_PERIOD_PS = 4000;      // 250 MHz
	localparam int TICK_PS       = 1000000;   // 1 us
	localparam int TICK_CYC      = TICK_PS / CLK_PERIOD_PS;
	localparam int TICK_W        = 8;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	// timer phases
	typedef enum logic [1:0] {TS_IDLE, TS_DELAY, TS_PULSE} tlc_tmr_state_t;

	// true when a signal meets its activation mode this cycle
	function automatic logic act_hit(input logic [1:0] mode,
		input logic cur, input logic prev);
		unique case (mode)
			ACT_RISE: act_hit = cur & ~prev;
			ACT_FALL: act_hit = ~cur & prev;
			ACT_HIGH: act_hit = cur;
			ACT_LOW:  act_hit = ~cur;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== verification/tlc_top_tb.sv
// self-checking bench for the trigger logic, counter and timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
	failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, \
	(got), (exp)); end end
module tlc_top_tb;
	import tlc_pkg::*;
	logic              mclk;     // 250 MHz clock
	logic              rst_n;    // async reset, low
	logic [NEXT-1:0]   ext_in;   // external triggers
	logic              cfg_we;   // write strobe
	logic [FEAT_W-1:0] cfg_feat; // feature code
	logic [SEL_W-1:0]  cfg_sel;  // instance selector
	logic [SUB_W-1:0]  cfg_sub;  // block input selector
	logic [DATA_W-1:0] cfg_data; // write data
	logic [DATA_W-1:0] rd_data;  // read-back
	logic [NLB-1:0]    lb_out;   // logic block outputs
	logic [NSW-1:0]    sw_out;   // software pulses
	logic [NTMR-1:0]   tmr_out;  // timer pulses
	int                failures; // mismatches
	int                n_checks; // comparisons made
	logic [31:0]       q;        // read result
	int                n;        // measured cycles
	logic              a, b;     // expected block inputs
	// input count table: count, inputs, expected output
	logic [2:0] nn [4] = '{3'h1, 3'h3, 3'h2, 3'h0};
	logic [1:0] ee [4] = '{2'h1, 2'h3, 2'h3, 2'h3};
	logic       xx [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	////////////////////////////////////////////////////////////////////
	// clock and device under test
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	tlc_top u_tlc_top (.mclk(mclk), .rst_n(rst_n), .ext_in(ext_in),
		.cfg_we(cfg_we), .cfg_feat(cfg_feat), .cfg_sel(cfg_sel),
		.cfg_sub(cfg_sub), .cfg_data(cfg_data), .rd_data(rd_data),
		.lb_out(lb_out), .sw_out(sw_out), .tmr_out(tmr_out));

	////////////////////////////////////////////////////////////////////
	// access tasks; inputs always move 1 ns after a rising edge
	task automatic end_of_test;
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// strobe dropped a cycle before the next write, never same step
	task automatic wr(input logic [3:0] f, input int s, input int u,
		input logic [31:0] d);
		cfg_we = 1'b1;
		cfg_feat = f;
		cfg_sel = SEL_W'(s);
		cfg_sub = SUB_W'(u);
		cfg_data = d;
		step(1);
		cfg_we = 1'b0;
		step(1);
	endtask

	// address at one edge, data registered at the next
	task automatic rd(input logic [3:0] f, input int s,
		output logic [31:0] r);
		cfg_feat = f;
		cfg_sel = SEL_W'(s);
		step(2);
		r = rd_data;
	endtask

	task automatic evpulse(input int i);
		ext_in[i] = 1'b1;
		step(2);
		ext_in[i] = 1'b0;
		step(2);
	endtask

	// bounded wait for a timer level; hang set means a timeout fails
	task automatic wtmr(input int i, input logic l, input int lim,
		input bit hang, output int k);
		k = 0;
		while (tmr_out[i] !== l && k < lim) begin
			step(1);
			k++;
		end
		if (k >= lim && hang) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, tmr_out, l);
			end_of_test;
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		failures = 0;
		n_checks = 0;
		rst_n = 1'b0;
		ext_in = '0;
		cfg_we = 1'b0;
		cfg_feat = '0;
		cfg_sel = '0;
		cfg_sub = '0;
		cfg_data = '0;
		repeat (5) @(posedge mclk);
		#1 rst_n = 1'b1;
		step(1);
		`CHK({lb_out, sw_out, tmr_out}, 6'h00)
		rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h0)
		rd(F_TMR_VALUE, 1, q); `CHK(q, 32'h0)
		rd(4'hf, 0, q); `CHK(q, 32'h0)
		rd(F_LB_INNUM, 0, q); `CHK(q, 32'(INNUM_RST))
		// software pulses: one cycle high on the chosen channel only
		for (int s = 0; s < NSW; s++) begin
			cfg_we = 1'b1;
			cfg_feat = F_SW_PULSE;
			cfg_sel = SEL_W'(s);
			step(1);
			cfg_we = 1'b0;
			`CHK(sw_out, 2'(1 << s))
			step(1);
			`CHK(sw_out, 2'h0)
		end
		// logic block 0 fed by two external lines, every function
		wr(F_LB_INSRC, 0, 0, 32'(SRC_EXT0));
		wr(F_LB_INSRC, 0, 1, 32'(SRC_EXT0 + 1));
		wr(F_LB_INNUM, 0, 0, 32'h2);
		rd(F_LB_INSRC, 0, q); `CHK(q, 32'(SRC_EXT0))
		for (int fn = 0; fn < 2; fn++)
			for (int iv = 0; iv < 2; iv++)
				for (int v = 0; v < 4; v++) begin
					wr(F_LB_FUNC, 0, 0, 32'(fn));
					wr(F_LB_INV, 0, 1, 32'(iv));
					ext_in[1:0] = 2'(v);
					step(3);
					a = ext_in[0];
					b = ext_in[1] ^ iv[0];
					`CHK(lb_out[0], fn ? a | b : a & b)
				end
		// inactive inputs: third input sources constant zero
		wr(F_LB_FUNC, 0, 0, 32'(FN_AND));
		wr(F_LB_INV, 0, 1, 32'h0);
		for (int t = 0; t < 4; t++) begin
			wr(F_LB_INNUM, 0, 0, 32'(nn[t]));
			ext_in[1:0] = ee[t];
			step(3);
			`CHK(lb_out[0], xx[t])
		end
		ext_in = '0;
		// counter 0 counts rising edges of line 2
		wr(F_CNT_EVSRC, 0, 0, 32'(SRC_EXT0 + 2));
		rd(F_CNT_EVSRC, 0, q); `CHK(q, 32'(SRC_EXT0 + 2))
		repeat (3) evpulse(2);
		rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h3)
		rd(F_CNT_VALUE, 1, q); `CHK(q, 32'h0)
		wr(F_CNT_VALUE, 0, 0, 32'h10);
		evpulse(2);
		rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h11)
		wr(F_CNT_RESET, 0, 0, 32'h0);
		rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h0)
		evpulse(2);
		rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h1)
		// hardware reset from line 3 under every activation mode
		wr(F_CNT_RSTSRC, 0, 0, 32'(SRC_EXT0 + 3));
		for (int m = 0; m < 4; m++) begin
			ext_in[3] = m[0];
			wr(F_CNT_RSTACT, 0, 0, 32'(m));
			step(2);
			wr(F_CNT_VALUE, 0, 0, 32'h5);
			rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h5)
			ext_in[3] = ~m[0];
			step(3);
			rd(F_CNT_VALUE, 0, q); `CHK(q, 32'h0)
		end
		wr(F_CNT_RSTSRC, 0, 0, 32'(SRC_ZERO));
		ext_in = '0;
		// timer 0: 2 us delay, 3 us pulse; tick granularity allowed
		wr(F_TMR_DELAY, 0, 0, 32'h2);
		wr(F_TMR_DUR, 0, 0, 32'h3);
		wr(F_TMR_TRGSRC, 0, 0, 32'(SRC_EXT0));
		rd(F_TMR_DELAY, 0, q); `CHK(q, 32'h2)
		rd(F_TMR_DUR, 0, q); `CHK(q, 32'h3)
		rd(F_TMR_TRGSRC, 0, q); `CHK(q, 32'(SRC_EXT0))
		ext_in[0] = 1'b1;
		wtmr(0, 1'b1, 700, 1, n);
		`CHK(n >= 248 && n <= 506, 1'b1)
		ext_in[0] = 1'b0;
		step(2);
		ext_in[0] = 1'b1;
		wtmr(0, 1'b0, 1000, 1, n);
		`CHK(n + 2 >= 498 && n + 2 <= 756, 1'b1)
		// the edge during the pulse must not start a new cycle
		wtmr(0, 1'b1, 600, 0, n); `CHK(n, 600)
		// long delay cut short by a value write
		wr(F_TMR_DELAY, 0, 0, 32'd100);
		ext_in[0] = 1'b0;
		step(2);
		ext_in[0] = 1'b1;
		step(300);
		rd(F_TMR_VALUE, 0, q); `CHK(q >= 98 && q <= 100, 1'b1)
		wr(F_TMR_VALUE, 0, 0, 32'h1);
		wtmr(0, 1'b1, 300, 1, n);
		wtmr(0, 1'b0, 1000, 1, n);
		// timer 1 started by software channel 1, no delay
		wr(F_TMR_DUR, 1, 0, 32'h1);
		wr(F_TMR_TRGSRC, 1, 0, 32'(SRC_SW0 + 1));
		wr(F_SW_PULSE, 1, 0, 32'h0);
		wtmr(1, 1'b1, 6, 1, n);
		wtmr(1, 1'b0, 300, 1, n);
		// every trigger activation mode on line 1
		wr(F_TMR_TRGSRC, 1, 0, 32'(SRC_EXT0 + 1));
		for (int m = 0; m < 4; m++) begin
			ext_in[1] = m[0];
			wr(F_TMR_TRGACT, 1, 0, 32'(m));
			step(4);
			wtmr(1, 1'b0, 300, 1, n);
			wtmr(1, 1'b1, 10, 0, n); `CHK(n, 10)
			ext_in[1] = ~m[0];
			wtmr(1, 1'b1, 8, 1, n);
		end
		end_of_test;
	end
endmodule // tlc_top_tb
`default_nettype wire
